// ==== rtl/watchdog_pkg.sv ====
// constants shared by the watchdog with sleep control
// assumes a single pclk domain; nothing outside this package is referenced
package watchdog_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] CAUSE_OFFSET = 12'h004;
  localparam logic [11:0] CONFIG_OFFSET = 12'h008;
  // ----------------------------------------------------------------
  // watchdog_and_sleep_control fields
  // ----------------------------------------------------------------
  localparam int SW_ON_BIT = 0;
  localparam int SINK_BIT = 1;
  localparam int ULP_EN_BIT = 2;
  localparam int SRET_BIT = 4;
  localparam int LEVEL_BIT = 5;
  localparam int REGULATOR_SLEEP_LOWPOWER_BIT = 7;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h97;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // reset_cause_status and config fields
  // ----------------------------------------------------------------
  localparam int TIMEOUT_BIT = 0;
  localparam int RUNNING_BIT = 1;
  localparam int MODE_LSB = 0;
  localparam int SEL_LSB = 2;
  localparam int ULP_REGULATOR_CONFIG_DISABLE_BIT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // ----------------------------------------------------------------
  // enable mode encodings of the two-bit configuration field
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_RUN_ONLY = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int BASE_PERIOD_US = 4000;
  localparam int LF_OSC_HZ = 31250;
  localparam int BASE_TICKS = BASE_PERIOD_US * LF_OSC_HZ / 1000000;
endpackage

// ==== rtl/watchdog_sleep_ctrl.sv ====
// watchdog timer with sleep and regulator control, apb register slave
// assumes lf_osc_tick is a one-pclk pulse per low-frequency oscillator period,
// and that instruction strobes from the core are single-cycle pulses on pclk
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module watchdog_sleep_ctrl #(
  parameter int PS_WIDTH = 16,
  parameter int BASE_TICKS = watchdog_pkg::BASE_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lf_osc_tick,
  input wire logic clear_watchdog_instr,
  input wire logic sleep_instr,
  input wire logic sleep_active,
  input wire logic [2:0] internal_osc_freq_select,
  input wire logic clock_fail,
  input wire logic regulator_enabled,
  input wire logic ulp_wake_comparator_out,
  output logic low_freq_internal_osc_on,
  output logic watchdog_timeout,
  output logic regulator_standby,
  output logic regulator_ultra_low,
  output logic ulp_wake_enable,
  output logic ulp_current_sink_enable
);
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] config_reg;
  logic timeout_flag_reg;
  logic [31:0] prdata_reg;
  logic [2:0] freq_sel_reg;
  logic [$clog2(BASE_TICKS+1)-1:0] base_cnt_reg;
  logic [PS_WIDTH-1:0] ps_cnt_reg;
  logic timeout_reg;

  // zero wait states; a frozen clock enable stalls the transfer
  wire setup_phase = psel & ~penable & pclk_en;
  wire access_phase = psel & penable & pclk_en;
  wire hit_ctrl = (paddr == watchdog_pkg::CTRL_OFFSET);
  wire hit_cause = (paddr == watchdog_pkg::CAUSE_OFFSET);
  wire hit_config = (paddr == watchdog_pkg::CONFIG_OFFSET);
  wire mapped = hit_ctrl | hit_cause | hit_config;
  wire wr_en = access_phase & pwrite & mapped;
  wire ctrl_wr = wr_en & hit_ctrl;
  wire cause_wr = wr_en & hit_cause;
  wire config_wr = wr_en & hit_config;
  assign pready = pclk_en;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [1:0] mode = config_reg[watchdog_pkg::MODE_LSB +: 2];
  wire [4:0] sel = config_reg[watchdog_pkg::SEL_LSB +: 5];
  wire ulp_regulator_config_disable = config_reg[watchdog_pkg::ULP_REGULATOR_CONFIG_DISABLE_BIT];
  wire sw_on = ctrl_reg[watchdog_pkg::SW_ON_BIT];
  // software bit only matters in software mode
  wire wdt_on = (mode == watchdog_pkg::MODE_ON) |
    (mode == watchdog_pkg::MODE_SW & sw_on) |
    (mode == watchdog_pkg::MODE_RUN_ONLY & ~sleep_active);

  // ----------------------------------------------------------------
  // clear sources and time-out
  // ----------------------------------------------------------------
  wire freq_changed = (freq_sel_reg != internal_osc_freq_select);
  wire instr_clear = clear_watchdog_instr | sleep_instr;
  // a disabled watchdog is held at zero so an enable starts a full period
  wire count_clear = instr_clear | freq_changed | clock_fail | ~wdt_on;
  wire base_done = lf_osc_tick & (base_cnt_reg == BASE_TICKS - 1);
  // postscaler clamps its select at the counter width
  wire [4:0] sel_clamped = (sel > 5'(PS_WIDTH)) ? 5'(PS_WIDTH) : sel;
  wire [PS_WIDTH:0] ps_limit = ({{PS_WIDTH{1'b0}}, 1'b1} << sel_clamped) - 1'b1;
  wire ps_done = ({1'b0, ps_cnt_reg} == ps_limit);
  wire fire = base_done & ps_done & ~count_clear;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // the level bit is live from the comparator; bits 6 and 3 are zero
  wire [7:0] ctrl_view = (ctrl_reg & watchdog_pkg::CTRL_WRITE_MASK) |
    (8'(ulp_wake_comparator_out) << watchdog_pkg::LEVEL_BIT);
  wire [7:0] cause_view = (8'(timeout_flag_reg) << watchdog_pkg::TIMEOUT_BIT) |
    (8'(wdt_on) << watchdog_pkg::RUNNING_BIT);
  wire [7:0] rd_mux = hit_ctrl ? ctrl_view :
    hit_cause ? cause_view :
    hit_config ? config_reg : 8'h00;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // only writable bits are kept, so reserved bits can never be set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= watchdog_pkg::CTRL_RESET;
      config_reg <= watchdog_pkg::CONFIG_RESET;
    end else if (pclk_en) begin
      if (ctrl_wr) begin
        ctrl_reg <= pwdata[7:0] & watchdog_pkg::CTRL_WRITE_MASK;
      end
      if (config_wr) begin
        config_reg <= pwdata[7:0];
      end
    end
  end

  // read data captured in the setup phase so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_reg <= {24'h00_0000, rd_mux};
    end
  end
  assign prdata = prdata_reg;

  // sticky time-out flag, write one to clear; a new time-out wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_reg <= 1'b0;
    end else if (pclk_en) begin
      if (fire) begin
        timeout_flag_reg <= 1'b1;
      end else if (cause_wr & pwdata[watchdog_pkg::TIMEOUT_BIT]) begin
        timeout_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // base divider counts oscillator ticks, postscaler counts base periods
  // a clear in the same cycle as expiry wins, so a late clear-watchdog
  // instruction still rescues the device; the time-out pulse is registered
  // to keep the reset request free of glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt_reg <= '0;
      ps_cnt_reg <= '0;
      timeout_reg <= 1'b0;
      freq_sel_reg <= 3'h0;
    end else if (pclk_en) begin
      freq_sel_reg <= internal_osc_freq_select;
      timeout_reg <= fire;
      if (count_clear | fire) begin
        base_cnt_reg <= '0;
        ps_cnt_reg <= '0;
      end else if (base_done) begin
        base_cnt_reg <= '0;
        ps_cnt_reg <= ps_cnt_reg + 1'b1;
      end else if (lf_osc_tick) begin
        base_cnt_reg <= base_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // ultra-low-power sleep overrides the plain standby choice
  wire ulp_sleep = sleep_active & ctrl_reg[watchdog_pkg::SRET_BIT] & ~ulp_regulator_config_disable &
    regulator_enabled;
  assign regulator_ultra_low = ulp_sleep;
  assign regulator_standby = sleep_active & ~ulp_sleep &
    ctrl_reg[watchdog_pkg::REGULATOR_SLEEP_LOWPOWER_BIT];
  assign ulp_wake_enable = ctrl_reg[watchdog_pkg::ULP_EN_BIT];
  assign ulp_current_sink_enable = ctrl_reg[watchdog_pkg::SINK_BIT] &
    ctrl_reg[watchdog_pkg::ULP_EN_BIT];
  assign low_freq_internal_osc_on = wdt_on;
  assign watchdog_timeout = timeout_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  osc_follows_on_a: assert property (
    wdt_on |-> low_freq_internal_osc_on)
    else $error("oscillator not requested while watchdog enabled");
  base_wrap_a: assert property (
    pclk_en & base_done & ~count_clear & ~ps_done |=>
      base_cnt_reg == 0 && ps_cnt_reg == $past(ps_cnt_reg) + 1'b1)
    else $error("postscaler did not step on base period end");
  fire_select_a: assert property (
    watchdog_timeout |-> $past(ps_done) && $past(base_done))
    else $error("time-out without selected postscaler output");
  instr_clear_a: assert property (
    pclk_en & instr_clear |=> base_cnt_reg == 0 && ps_cnt_reg == 0)
    else $error("instruction did not clear counts");
  freq_clear_a: assert property (
    pclk_en & freq_changed |=> base_cnt_reg == 0 && ps_cnt_reg == 0)
    else $error("frequency select change did not clear counts");
  fail_clear_a: assert property (
    pclk_en & clock_fail |=> ps_cnt_reg == 0 && !watchdog_timeout)
    else $error("clock failure did not clear counts");
  sw_ignored_a: assert property (
    mode == watchdog_pkg::MODE_ON |-> wdt_on)
    else $error("hardware-enabled watchdog turned off");
  off_holds_a: assert property (
    pclk_en & ~wdt_on |=> base_cnt_reg == 0 && ps_cnt_reg == 0)
    else $error("disabled watchdog still counting");
  reserved_zero_a: assert property (
    setup_phase & hit_ctrl |=> prdata[6] == 1'b0 && prdata[3] == 1'b0)
    else $error("reserved control bits read nonzero");
  sink_gated_a: assert property (
    ulp_current_sink_enable |-> ulp_wake_enable)
    else $error("current sink on without wake module");
  timeout_pulse_a: assert property (
    watchdog_timeout |=> !watchdog_timeout || $past(fire))
    else $error("time-out pulse stretched");
  // regulator outputs only in sleep, and the two modes never overlap
  standby_sleep_a: assert property (
    regulator_standby |-> sleep_active && ctrl_reg[watchdog_pkg::REGULATOR_SLEEP_LOWPOWER_BIT] &&
      !regulator_ultra_low)
    else $error("regulator standby outside its sleep conditions");
  ultra_low_a: assert property (
    regulator_ultra_low |-> sleep_active && regulator_enabled && !ulp_regulator_config_disable &&
      ctrl_reg[watchdog_pkg::SRET_BIT])
    else $error("ultra-low regulator mode without its conditions");
  standby_needed_a: assert property (
    sleep_active && ctrl_reg[watchdog_pkg::REGULATOR_SLEEP_LOWPOWER_BIT] && !regulator_ultra_low |->
      regulator_standby)
    else $error("regulator standby missing in sleep");
  // wake module and comparator level
  wake_enable_a: assert property (
    ulp_wake_enable == ctrl_reg[watchdog_pkg::ULP_EN_BIT])
    else $error("wake module enable does not follow its bit");
  level_read_a: assert property (
    setup_phase & hit_ctrl |=>
      prdata[watchdog_pkg::LEVEL_BIT] == $past(ulp_wake_comparator_out))
    else $error("comparator level not read back");
  // enable modes; the hardware-on mode is watched above
  mode_off_a: assert property (
    mode == watchdog_pkg::MODE_OFF |-> !wdt_on)
    else $error("watchdog running in off mode");
  sw_mode_a: assert property (
    mode == watchdog_pkg::MODE_SW |-> wdt_on == sw_on)
    else $error("software mode ignores the enable bit");
  run_only_a: assert property (
    mode == watchdog_pkg::MODE_RUN_ONLY |-> wdt_on == !sleep_active)
    else $error("run-only mode wrong in sleep or run");
  // register writes keep only the implemented bits
  ctrl_write_a: assert property (
    pclk_en & ctrl_wr |=>
      ctrl_reg == ($past(pwdata[7:0]) & watchdog_pkg::CTRL_WRITE_MASK))
    else $error("control write not masked to implemented bits");
  config_write_a: assert property (
    pclk_en & config_wr |=> config_reg == $past(pwdata[7:0]))
    else $error("config write lost");
  cause_read_a: assert property (
    setup_phase & hit_cause |=> prdata[watchdog_pkg::RUNNING_BIT] == $past(wdt_on))
    else $error("running bit not read back");
  // time-out flag: set wins over a clear in the same cycle
  flag_set_a: assert property (
    pclk_en & fire |=> timeout_flag_reg)
    else $error("time-out flag not set");
  flag_clear_a: assert property (
    pclk_en & cause_wr & pwdata[watchdog_pkg::TIMEOUT_BIT] & ~fire |=> !timeout_flag_reg)
    else $error("time-out flag not cleared by write one");
  // a frozen clock enable holds every count and the time-out output
  frozen_hold_a: assert property (
    !pclk_en |=> $stable(base_cnt_reg) && $stable(ps_cnt_reg) && $stable(watchdog_timeout))
    else $error("state moved while clock enable low");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  // main scenarios: time-out, ultra-low sleep, software enable, freeze
  timeout_seen_c: cover property (watchdog_timeout);
  sleep_ulp_c: cover property (regulator_ultra_low);
  sw_enable_c: cover property (mode == watchdog_pkg::MODE_SW ##1 wdt_on);
  freeze_c: cover property (!pclk_en ##1 pclk_en);
  run_only_sleep_c: cover property (mode == watchdog_pkg::MODE_RUN_ONLY && sleep_active);
endmodule

// ==== dv/cpu_core_model.sv ====
// processor-side model: low-frequency tick source and instruction strobes
// assumes the watchdog samples every output on the rising edge of pclk
`timescale 1ns/1ns
module cpu_core_model #(
  parameter int TICK_DIV = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic lf_osc_tick,
  output logic clear_watchdog_instr,
  output logic sleep_instr
);
  int div_reg;
  // ------------------------------------------------------------
  // oscillator tick, spaced wide so strobes fit between ticks
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 0;
      lf_osc_tick <= 1'b0;
    end else begin
      div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
      lf_osc_tick <= (div_reg == TICK_DIV - 1);
    end
  end
  // single-cycle instruction strobe, raised just after an edge
  task automatic issue(input bit is_sleep);
    @(posedge pclk);
    clear_watchdog_instr <= !is_sleep;
    sleep_instr <= is_sleep;
    @(posedge pclk);
    clear_watchdog_instr <= 1'b0;
    sleep_instr <= 1'b0;
  endtask
  initial begin
    clear_watchdog_instr = 1'b0;
    sleep_instr = 1'b0;
  end
endmodule

// ==== dv/tb_watchdog_sleep_ctrl.sv ====
// self-checking bench for the watchdog with sleep control
// assumes pclk_en high except in the freeze scenario; the core model supplies ticks
`timescale 1ns/1ns
module tb_watchdog_sleep_ctrl;
  localparam int BT = 4;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleep_active = 1'b0, clock_fail = 1'b0, regulator_enabled = 1'b0, ulp_cmp = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0] freq_sel = 3'h0;
  logic ce = 1'b1;
  logic pready, pslverr, err, tick, clr_i, slp_i, osc_on, wd_to, stby, ulp, ulp_en, sink;
  int err_count = 0, compares = 0, cyc = 0, n;
  watchdog_sleep_ctrl #(.BASE_TICKS(BT)) watchdog_sleep_ctrl_i (.pclk(pclk),
    .presetn(presetn), .pclk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lf_osc_tick(tick), .clear_watchdog_instr(clr_i), .sleep_instr(slp_i),
    .sleep_active(sleep_active), .internal_osc_freq_select(freq_sel),
    .clock_fail(clock_fail), .regulator_enabled(regulator_enabled),
    .ulp_wake_comparator_out(ulp_cmp), .low_freq_internal_osc_on(osc_on),
    .watchdog_timeout(wd_to), .regulator_standby(stby), .regulator_ultra_low(ulp),
    .ulp_wake_enable(ulp_en), .ulp_current_sink_enable(sink));
  cpu_core_model cpu_core_model_i (.pclk(pclk), .presetn(presetn), .lf_osc_tick(tick),
    .clear_watchdog_instr(clr_i), .sleep_instr(slp_i));
  // ------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // a few thousand cycles suffice; far beyond that means a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // apb transfer, entered just after a rising edge; holds until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // ticks counted until the time-out pulse shows
  task automatic ticks_to_fire(output int t);
    t = 0;
    repeat (3000) begin
      @(posedge pclk);
      if (wd_to === 1'b1) return;
      if (tick === 1'b1) t++;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, watchdog_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl reset", rd, 32'h0000_0000);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'hffff_fff8);
    apb(1'b0, watchdog_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl mask", rd, 32'h0000_0090);
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'h0000_0002);
    chk("sink alone", {31'h0, sink}, 32'h0);
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'h0000_0006);
    ulp_cmp <= 1'b1;
    apb(1'b0, watchdog_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl level", rd, 32'h0000_0026);
    chk("ulp en sink", {30'h0, ulp_en, sink}, 32'h0000_0003);
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'h0);
  endtask
  // every enable mode against software bit and sleep state
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'(k & 1));
        apb(1'b1, watchdog_pkg::CONFIG_OFFSET, 32'(m));
        sleep_active <= k[1];
        @(posedge pclk);
        @(posedge pclk);
        chk("osc on", {31'h0, osc_on}, 32'((m == 3) || (m == 1 && k[0]) ||
          (m == 2 && !k[1])));
      end
    end
    sleep_active <= 1'b0;
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'h0);
  endtask
  task automatic t_periods();
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, watchdog_pkg::CONFIG_OFFSET, 32'(3 + (s << 2)));
      ticks_to_fire(n);
      ticks_to_fire(n);
      chk("period", 32'(n), 32'(BT << s));
    end
    apb(1'b0, watchdog_pkg::CAUSE_OFFSET, 32'h0);
    chk("cause flag", {31'h0, rd[0]}, 32'h0000_0001);
  endtask
  // each clearing event restarts a fresh full period
  task automatic t_clears();
    apb(1'b1, watchdog_pkg::CONFIG_OFFSET, 32'h0000_0003);
    for (int ev = 0; ev < 4; ev++) begin
      ticks_to_fire(n);
      repeat (2) @(posedge pclk iff tick === 1'b1);
      if (ev < 2) cpu_core_model_i.issue(ev == 1);
      else begin
        @(posedge pclk);
        if (ev == 2) freq_sel <= freq_sel + 3'h1;
        else clock_fail <= 1'b1;
        @(posedge pclk);
        clock_fail <= 1'b0;
      end
      ticks_to_fire(n);
      chk("after clear", 32'(n), 32'(BT));
    end
  endtask
  // a low clock enable must hold the counts: no time-out while frozen
  task automatic t_freeze();
    int seen;
    seen = 0;
    ticks_to_fire(n);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (40) begin
      @(posedge pclk);
      if (wd_to === 1'b1) seen++;
    end
    ce <= 1'b1;
    chk("frozen fire", 32'(seen), 32'h0000_0000);
    ticks_to_fire(n);
    chk("after freeze", 32'(n), 32'(BT));
  endtask
  task automatic t_regulator();
    sleep_active <= 1'b1;
    regulator_enabled <= 1'b1;
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'h0000_0080);
    chk("standby", {30'h0, stby, ulp}, 32'h0000_0002);
    apb(1'b1, watchdog_pkg::CTRL_OFFSET, 32'h0000_0090);
    chk("ultra low", {30'h0, stby, ulp}, 32'h0000_0001);
    apb(1'b1, watchdog_pkg::CONFIG_OFFSET, 32'h0000_0080);
    chk("retention off", {30'h0, stby, ulp}, 32'h0000_0002);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_modes();
    t_periods();
    t_clears();
    t_freeze();
    t_regulator();
    report_and_stop();
  end
endmodule
